//--- charger_pkg.sv
package charger_pkg;
    // Charge current command codes
    localparam logic [1:0] CUR_ZERO = 2'h0;
    localparam logic [1:0] CUR_TENTH = 2'h1;
    localparam logic [1:0] CUR_FULL = 2'h2;
    localparam logic [1:0] CUR_VOLT = 2'h3;
    // Phase durations in minutes (prequal in tenths of a minute), with a 1 nF timing capacitor
    localparam int PREQUAL_MIN_X10 = 75;
    localparam int FAST_MIN = 90;
    localparam int FULL_MIN = 90;
    localparam int TOPOFF_MIN = 45;
    // Clock rate and slow tick
    localparam int CLK_HZ = 20000000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICKS_PER_MIN = 60000 / TICK_MS;
    localparam int PREQUAL_TICKS = PREQUAL_MIN_X10 * TICKS_PER_MIN / 10;
    localparam int FAST_TICKS = FAST_MIN * TICKS_PER_MIN;
    localparam int FULL_TICKS = FULL_MIN * TICKS_PER_MIN;
    localparam int TOPOFF_TICKS = TOPOFF_MIN * TICKS_PER_MIN;
    localparam int TIMER_W = 16;

    typedef enum logic [7:0] {
        ST_RESET = 8'h01,
        ST_PREQUAL = 8'h02,
        ST_FAST = 8'h04,
        ST_FULL = 8'h08,
        ST_TOPOFF = 8'h10,
        ST_DONE = 8'h20,
        ST_PAUSE = 8'h40,
        ST_FAULT = 8'h80
    } chg_state_e;
endpackage : charger_pkg

//--- tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int CYCLES = charger_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    output logic o_tick
);
    logic [31:0] cnt_r;

    always_ff @(posedge i_clk)
    begin
        if (i_srst || cnt_r == 32'(CYCLES - 1))
            cnt_r <= 32'h0;
        else
            cnt_r <= cnt_r + 32'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_tick <= 1'b0;
        else
            o_tick <= (cnt_r == 32'(CYCLES - 1));
    end
endmodule : tick_divider
`default_nettype wire

//--- phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
    parameter int W = charger_pkg::TIMER_W
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_run,
    input wire logic i_tick,
    input wire logic [W-1:0] i_limit,
    output logic o_expired,
    output logic [W-1:0] o_count
);
    // Holds its count while not running, so a pause resumes in place
    always_ff @(posedge i_clk)
    begin
        if (i_srst || i_clear)
            o_count <= '0;
        else if (i_run && i_tick && o_count != i_limit)
            o_count <= o_count + 1'b1;
    end

    assign o_expired = (o_count == i_limit);
endmodule : phase_timer
`default_nettype wire

//--- li_ion_charge_state_machine.sv
// Behaviour
// R1: Power-on, or done with low/dropout/overvoltage battery, goes to reset.
// R2: Reset clears timers, commands zero current, releases all indicators.
// R3: Leave reset only when supply, reference and bias are all good; the code leaves for fault on a hot battery regardless.
// R4: Prequal commands tenth current, constant-current indicator low only.
// R5: Prequal is limited by timer A, typically 7.5 minutes.
// R6: Prequal to fast charge when above undervoltage and temperature ok.
// R7: Prequal timeout below undervoltage goes to fault, fault indicator low.
// R8: Fast charge commands full current, indicator low, timer B 90 min.
// R9: Fast to full charge at regulation voltage; timer B expiry is fault.
// R10: Full charge is constant voltage, its indicator low, timer A 90 min.
// R11: Full to top-off on timer A expiry or low-current comparator.
// R12: Top-off is constant voltage, indicators high, timer A 45 min.
// R13: Top-off expiry goes to done, zero current, stays until recharge.
// R14: Out of temperature pauses: zero current, timer frozen, indicators kept.
// R15: Reset goes straight to fault when battery is at or above max temp.
// R16: Fault commands zero current, fault indicator low, others high.
// R17: Leaving power-down puts the controller into reset like power-on.
// R18: Fault is latched until power cycle or power-down input.
// R19: Power-down low stops charging, switch off, indicators high impedance.
// R20: Phase timers count a common slow tick with parameter limits.
// R21: Each open-drain indicator enable pulls low when asserted.
`timescale 1ns/1ps
`default_nettype none
module li_ion_charge_state_machine #(
    parameter int TICK_CYCLES = charger_pkg::TICK_CYCLES,
    parameter int PREQUAL_TICKS = charger_pkg::PREQUAL_TICKS,
    parameter int FAST_TICKS = charger_pkg::FAST_TICKS,
    parameter int FULL_TICKS = charger_pkg::FULL_TICKS,
    parameter int TOPOFF_TICKS = charger_pkg::TOPOFF_TICKS
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_power_down_input_n,
    input wire logic i_supply_good,
    input wire logic i_ref_good,
    input wire logic i_bias_good,
    input wire logic i_above_undervoltage,
    input wire logic i_at_regulation,
    input wire logic i_below_recharge,
    input wire logic i_overvoltage,
    input wire logic i_dropout,
    input wire logic i_temp_ok,
    input wire logic i_temp_over_max,
    input wire logic i_low_current,
    output logic [1:0] o_current_cmd,
    output logic o_switch_enable,
    output logic o_const_current_indicator_n_out,
    output logic o_const_current_indicator_n_oe_n,
    output logic o_const_voltage_indicator_n_out,
    output logic o_const_voltage_indicator_n_oe_n,
    output logic o_fault_indicator_n_out,
    output logic o_fault_indicator_n_oe_n,
    output logic [7:0] o_state
);
    localparam int TW = charger_pkg::TIMER_W;
    // Two flops per pin; no reset, so reset cannot fake a power-down
    localparam int NS = 12;
    logic [NS-1:0] meta_r;
    logic [NS-1:0] sync_r;
    logic power_down_input_n_n, sup_ok, ref_ok, bias_ok, above_uv, at_reg, below_rch;
    logic ovp, drop, temp_ok, temp_hot, low_i;

    always_ff @(posedge i_clk)
    begin
        meta_r <= {i_power_down_input_n, i_supply_good, i_ref_good,
                   i_bias_good, i_above_undervoltage, i_at_regulation,
                   i_below_recharge, i_overvoltage, i_dropout,
                   i_temp_ok, i_temp_over_max, i_low_current};
        sync_r <= meta_r;
    end
    assign {power_down_input_n_n, sup_ok, ref_ok, bias_ok, above_uv, at_reg, below_rch,
            ovp, drop, temp_ok, temp_hot, low_i} = sync_r;
    logic power_down_input_n_n_d_r, power_down_input_n_rise;
    // Reset to the idle pin level so no false edge follows reset
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            power_down_input_n_n_d_r <= 1'b1;
        else
            power_down_input_n_n_d_r <= power_down_input_n_n;
    end
    assign power_down_input_n_rise = power_down_input_n_n & ~power_down_input_n_n_d_r;
    charger_pkg::chg_state_e state_r, state_nxt, resume_r;
    // Slow tick and phase timers
    logic tick, clr_a, run_a, clr_b, run_b, exp_a, exp_b;
    logic [TW-1:0] lim_a, cnt_a, cnt_b;

    tick_divider #(.CYCLES(TICK_CYCLES)) u_tick (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .o_tick(tick)
    );

    assign lim_a = (state_r == charger_pkg::ST_PREQUAL) ? TW'(PREQUAL_TICKS)
                 : (state_r == charger_pkg::ST_TOPOFF) ? TW'(TOPOFF_TICKS)
                 : TW'(FULL_TICKS);
    // R20: shared tick timers
    phase_timer #(.W(TW)) u_phase_timer_a (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clear(clr_a),
        .i_run(run_a),
        .i_tick(tick),
        .i_limit(lim_a),
        .o_expired(exp_a),
        .o_count(cnt_a)
    );
    phase_timer #(.W(TW)) u_phase_timer_b (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clear(clr_b),
        .i_run(run_b),
        .i_tick(tick),
        .i_limit(TW'(FAST_TICKS)),
        .o_expired(exp_b),
        .o_count(cnt_b)
    );

    // R2: timers cleared in reset; timer A restarts per phase
    assign clr_a = (state_r == charger_pkg::ST_RESET) ||
                   (state_nxt != state_r && state_nxt != charger_pkg::ST_PAUSE
                    && state_r != charger_pkg::ST_PAUSE);
    assign clr_b = (state_r == charger_pkg::ST_RESET);
    // R5: timer A runs in prequal, full and top-off
    assign run_a = (state_r == charger_pkg::ST_PREQUAL) ||
                   (state_r == charger_pkg::ST_FULL) ||
                   (state_r == charger_pkg::ST_TOPOFF);
    // R8: timer B runs only in fast charge
    assign run_b = (state_r == charger_pkg::ST_FAST);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            charger_pkg::ST_RESET:
                // R15: hot battery faults from reset
                if (temp_hot)
                    state_nxt = charger_pkg::ST_FAULT;
                // R3: wait for supply, reference and bias
                else if (sup_ok && ref_ok && bias_ok)
                    state_nxt = charger_pkg::ST_PREQUAL;
            charger_pkg::ST_PREQUAL:
                // R6: advance when voltage and temperature qualify
                if (above_uv && temp_ok)
                    state_nxt = charger_pkg::ST_FAST;
                // R7: prequal timeout is a fault
                else if (exp_a && !above_uv)
                    state_nxt = charger_pkg::ST_FAULT;
                else if (!temp_ok)
                    state_nxt = charger_pkg::ST_PAUSE;
            charger_pkg::ST_FAST:
                // R9: regulation wins over a simultaneous timeout
                if (at_reg)
                    state_nxt = charger_pkg::ST_FULL;
                else if (exp_b)
                    state_nxt = charger_pkg::ST_FAULT;
                else if (!temp_ok)
                    state_nxt = charger_pkg::ST_PAUSE;
            charger_pkg::ST_FULL:
                // R11: timer or low current ends full charge
                if (exp_a || low_i)
                    state_nxt = charger_pkg::ST_TOPOFF;
                else if (!temp_ok)
                    state_nxt = charger_pkg::ST_PAUSE;
            charger_pkg::ST_TOPOFF:
                // R13: top-off expiry completes the cycle
                if (exp_a)
                    state_nxt = charger_pkg::ST_DONE;
                else if (!temp_ok)
                    state_nxt = charger_pkg::ST_PAUSE;
            charger_pkg::ST_DONE:
                // R1: recharge, dropout or overvoltage restarts
                if (below_rch || drop || ovp)
                    state_nxt = charger_pkg::ST_RESET;
            charger_pkg::ST_PAUSE:
                // R14: resume the interrupted phase
                if (temp_ok)
                    state_nxt = resume_r;
            charger_pkg::ST_FAULT:
                // R18: latched
                state_nxt = charger_pkg::ST_FAULT;
            default:
                state_nxt = charger_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        // R1: power-on and R17: power-down exit both enter reset
        if (i_srst || !power_down_input_n_n || power_down_input_n_rise)
            state_r <= charger_pkg::ST_RESET;
        else
            state_r <= state_nxt;
    end
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            resume_r <= charger_pkg::ST_PREQUAL;
        else if (state_nxt == charger_pkg::ST_PAUSE &&
                 state_r != charger_pkg::ST_PAUSE)
            resume_r <= state_r;
    end
    // Indicator levels: 1 means pulled low
    logic cc_on, cv_on, flt_on;
    logic [1:0] cur_nxt;
    always_comb
    begin
        cc_on = 1'b0;
        cv_on = 1'b0;
        flt_on = 1'b0;
        cur_nxt = charger_pkg::CUR_ZERO;
        unique case (state_r)
            charger_pkg::ST_PREQUAL:
            begin
                // R4: tenth current, constant-current indicator
                cur_nxt = charger_pkg::CUR_TENTH;
                cc_on = 1'b1;
            end
            charger_pkg::ST_FAST:
            begin
                // R8: full constant current
                cur_nxt = charger_pkg::CUR_FULL;
                cc_on = 1'b1;
            end
            charger_pkg::ST_FULL:
            begin
                // R10: constant voltage with its indicator
                cur_nxt = charger_pkg::CUR_VOLT;
                cv_on = 1'b1;
            end
            // R12: top-off keeps voltage regulation, indicators off
            charger_pkg::ST_TOPOFF: cur_nxt = charger_pkg::CUR_VOLT;
            charger_pkg::ST_PAUSE:
            begin
                // R14: indicators hold what the paused phase showed
                cc_on = ~o_const_current_indicator_n_out;
                cv_on = ~o_const_voltage_indicator_n_out;
                flt_on = ~o_fault_indicator_n_out;
            end
            // R16: fault indicator only
            charger_pkg::ST_FAULT: flt_on = 1'b1;
            default: cur_nxt = charger_pkg::CUR_ZERO;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_current_cmd <= charger_pkg::CUR_ZERO;
            o_switch_enable <= 1'b0;
            o_state <= charger_pkg::ST_RESET;
        end
        else
        begin
            // R19: power-down forces the switch off
            o_current_cmd <= power_down_input_n_n ? cur_nxt : charger_pkg::CUR_ZERO;
            o_switch_enable <= power_down_input_n_n && cur_nxt != charger_pkg::CUR_ZERO;
            o_state <= state_r;
        end
    end

    // R21: open-drain pins, enable low while pulling low
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_const_current_indicator_n_out <= 1'b1;
            o_const_voltage_indicator_n_out <= 1'b1;
            o_fault_indicator_n_out <= 1'b1;
            o_const_current_indicator_n_oe_n <= 1'b1;
            o_const_voltage_indicator_n_oe_n <= 1'b1;
            o_fault_indicator_n_oe_n <= 1'b1;
        end
        else
        begin
            // R19: all released while powered down
            o_const_current_indicator_n_out <= ~(cc_on && power_down_input_n_n);
            o_const_voltage_indicator_n_out <= ~(cv_on && power_down_input_n_n);
            o_fault_indicator_n_out <= ~(flt_on && power_down_input_n_n);
            o_const_current_indicator_n_oe_n <= ~(cc_on && power_down_input_n_n);
            o_const_voltage_indicator_n_oe_n <= ~(cv_on && power_down_input_n_n);
            o_fault_indicator_n_oe_n <= ~(flt_on && power_down_input_n_n);
        end
    end

    // R2: reset state commands zero current one cycle later
    a_reset_zero_cur: assert property (@(posedge i_clk) disable iff (i_srst)
        state_r == charger_pkg::ST_RESET |=> o_current_cmd == 2'h0)
        else $error("current not zero after reset state");
    // R7: prequal timeout goes to fault
    a_prequal_timeout: assert property (@(posedge i_clk) disable iff (i_srst)
        state_r == charger_pkg::ST_PREQUAL && exp_a && !above_uv && power_down_input_n_n
        && !power_down_input_n_rise |=> state_r == charger_pkg::ST_FAULT)
        else $error("prequal timeout missed");
    // R18: fault stays while powered
    a_fault_latched: assert property (@(posedge i_clk) disable iff (i_srst)
        state_r == charger_pkg::ST_FAULT && power_down_input_n_n |=>
        state_r == charger_pkg::ST_FAULT)
        else $error("fault left while powered");
    // R16: fault indicator low one cycle into fault
    a_fault_led: assert property (@(posedge i_clk) disable iff (i_srst)
        state_r == charger_pkg::ST_FAULT && power_down_input_n_n |=>
        !o_fault_indicator_n_oe_n && o_const_current_indicator_n_oe_n)
        else $error("fault indicators wrong");
    // R14: timer frozen during pause
    a_pause_freeze: assert property (@(posedge i_clk) disable iff (i_srst)
        state_r == charger_pkg::ST_PAUSE && $past(state_r) ==
        charger_pkg::ST_PAUSE |-> $stable(cnt_a) && $stable(cnt_b))
        else $error("timer moved in pause");
    // R19: powered down releases indicators within three cycles
    a_pd_release: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_power_down_input_n [*4] |-> o_fault_indicator_n_oe_n &&
        o_const_current_indicator_n_oe_n && !o_switch_enable)
        else $error("indicators driven in power-down");
    // R8: fast charge commands full current
    a_fast_cur: assert property (@(posedge i_clk) disable iff (i_srst)
        state_r == charger_pkg::ST_FAST && power_down_input_n_n |=> o_current_cmd == 2'h2)
        else $error("fast current wrong");
    // R13: done commands zero current
    a_done_cur: assert property (@(posedge i_clk) disable iff (i_srst)
        state_r == charger_pkg::ST_DONE |=> o_current_cmd == 2'h0 &&
        o_const_voltage_indicator_n_oe_n)
        else $error("done outputs wrong");
    // R3: no prequal without good supply
    a_reset_exit: assert property (@(posedge i_clk) disable iff (i_srst)
        $past(state_r) == charger_pkg::ST_RESET &&
        state_r == charger_pkg::ST_PREQUAL |->
        $past(sup_ok && ref_ok && bias_ok))
        else $error("left reset without good supply");
endmodule : li_ion_charge_state_machine
`default_nettype wire

//--- charger_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Status lamps on the far side: each pin has a pull-up, so a released
// pin reads high rather than keeping its last driven level.
module charger_partner (
    input wire logic i_cc_out,
    input wire logic i_cc_oe_n,
    input wire logic i_cv_out,
    input wire logic i_cv_oe_n,
    input wire logic i_flt_out,
    input wire logic i_flt_oe_n,
    output logic o_cc_pin,
    output logic o_cv_pin,
    output logic o_flt_pin
);
    assign o_cc_pin = i_cc_oe_n ? 1'b1 : i_cc_out;
    assign o_cv_pin = i_cv_oe_n ? 1'b1 : i_cv_out;
    assign o_flt_pin = i_flt_oe_n ? 1'b1 : i_flt_out;
endmodule : charger_partner
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Short counts keep every phase timeout to a few dozen cycles
    localparam int TC = 4;
    localparam int PT = 5;
    localparam int FT = 8;
    localparam int UT = 10;
    localparam int OT = 6;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pd_n = 1'b1;
    logic sup = 1'b0;
    logic refg = 1'b0;
    logic bias = 1'b0;
    logic uv = 1'b0;
    logic reg_ok = 1'b0;
    logic rech = 1'b0;
    logic ov = 1'b0;
    logic drop = 1'b0;
    logic tok = 1'b1;
    logic tmax = 1'b0;
    logic lowi = 1'b0;
    logic [1:0] cmd;
    logic sw_en;
    logic cc_out, cc_oe_n, cv_out, cv_oe_n, flt_out, flt_oe_n;
    logic cc_pin, cv_pin, flt_pin;
    logic [7:0] st;
    int err_total = 0;
    int checks_done = 0;

    always #25 clk = ~clk;

    li_ion_charge_state_machine #(.TICK_CYCLES(TC), .PREQUAL_TICKS(PT),
        .FAST_TICKS(FT), .FULL_TICKS(UT), .TOPOFF_TICKS(OT)) uut (
        .i_clk(clk), .i_srst(srst), .i_power_down_input_n(pd_n),
        .i_supply_good(sup), .i_ref_good(refg), .i_bias_good(bias),
        .i_above_undervoltage(uv), .i_at_regulation(reg_ok),
        .i_below_recharge(rech), .i_overvoltage(ov), .i_dropout(drop),
        .i_temp_ok(tok), .i_temp_over_max(tmax), .i_low_current(lowi),
        .o_current_cmd(cmd), .o_switch_enable(sw_en),
        .o_const_current_indicator_n_out(cc_out),
        .o_const_current_indicator_n_oe_n(cc_oe_n),
        .o_const_voltage_indicator_n_out(cv_out),
        .o_const_voltage_indicator_n_oe_n(cv_oe_n),
        .o_fault_indicator_n_out(flt_out),
        .o_fault_indicator_n_oe_n(flt_oe_n), .o_state(st));

    charger_partner lamps (.i_cc_out(cc_out), .i_cc_oe_n(cc_oe_n),
        .i_cv_out(cv_out), .i_cv_oe_n(cv_oe_n), .i_flt_out(flt_out),
        .i_flt_oe_n(flt_oe_n), .o_cc_pin(cc_pin), .o_cv_pin(cv_pin),
        .o_flt_pin(flt_pin));

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Pins are {constant current, constant voltage, fault} as seen on wire
    task automatic outs(input logic [1:0] c, input logic [2:0] pins);
        chk("current_cmd", {6'h00, cmd}, {6'h00, c});
        chk("indicator_pins", {5'h00, cc_pin, cv_pin, flt_pin},
            {5'h00, pins});
    endtask : outs

    // A missed state ends the run: later steps would only cascade
    task automatic wait_state(input logic [7:0] s, input int lim);
        int n;
        n = 0;
        while (st !== s && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (st !== s)
        begin
            err_total++;
            $display("BAD state_wait expected %h seen %h", s, st);
            test_done();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : wait_state

    task automatic do_reset(input logic s, input logic u, input logic tm);
        @(posedge clk);
        srst <= 1'b1;
        pd_n <= 1'b1;
        sup <= s;
        refg <= s;
        bias <= s;
        uv <= u;
        tmax <= tm;
        tok <= 1'b1;
        reg_ok <= 1'b0;
        rech <= 1'b0;
        lowi <= 1'b0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
    endtask : do_reset

    task automatic t_idle;
        do_reset(1'b0, 1'b0, 1'b0);
        repeat (10) @(posedge clk);
        #1;
        chk("state", st, 8'h01);
        outs(charger_pkg::CUR_ZERO, 3'h7);
        chk("switch", {7'h00, sw_en}, 8'h00);
        sup <= 1'b1;
        refg <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("state", st, 8'h01);
        $display("test idle finished");
    endtask : t_idle

    task automatic t_cycle;
        do_reset(1'b1, 1'b0, 1'b0);
        wait_state(8'h02, 20);
        outs(charger_pkg::CUR_TENTH, 3'h3);
        chk("switch", {7'h00, sw_en}, 8'h01);
        uv <= 1'b1;
        wait_state(8'h04, 20);
        outs(charger_pkg::CUR_FULL, 3'h3);
        tok <= 1'b0;
        wait_state(8'h40, 20);
        outs(charger_pkg::CUR_ZERO, 3'h3);
        tok <= 1'b1;
        wait_state(8'h04, 20);
        reg_ok <= 1'b1;
        wait_state(8'h08, 20);
        outs(charger_pkg::CUR_VOLT, 3'h5);
        lowi <= 1'b1;
        wait_state(8'h10, 20);
        outs(charger_pkg::CUR_VOLT, 3'h7);
        lowi <= 1'b0;
        repeat ((OT - 1) * TC - 4) @(posedge clk);
        #1;
        chk("state", st, 8'h10);
        wait_state(8'h20, 2 * TC + 10);
        outs(charger_pkg::CUR_ZERO, 3'h7);
        repeat (10) @(posedge clk);
        #1;
        chk("state", st, 8'h20);
        rech <= 1'b1;
        wait_state(8'h01, 20);
        rech <= 1'b0;
        // Second pass ends full charge on its timer, not on low current
        wait_state(8'h20, 30 + (UT + OT) * TC);
        drop <= 1'b1;
        wait_state(8'h01, 20);
        drop <= 1'b0;
        wait_state(8'h20, 30 + (UT + OT) * TC);
        ov <= 1'b1;
        wait_state(8'h01, 20);
        ov <= 1'b0;
        $display("test full cycle finished");
    endtask : t_cycle

    task automatic t_prequal_fault;
        do_reset(1'b1, 1'b0, 1'b0);
        wait_state(8'h02, 20);
        repeat ((PT - 1) * TC - 4) @(posedge clk);
        #1;
        chk("state", st, 8'h02);
        wait_state(8'h80, 3 * TC + 10);
        outs(charger_pkg::CUR_ZERO, 3'h6);
        uv <= 1'b1;
        sup <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk("state", st, 8'h80);
        pd_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("oe_n", {5'h00, cc_oe_n, cv_oe_n, flt_oe_n}, 8'h07);
        chk("switch", {7'h00, sw_en}, 8'h00);
        pd_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("state", st, 8'h01);
        $display("test prequal fault finished");
    endtask : t_prequal_fault

    task automatic t_fast_fault;
        do_reset(1'b1, 1'b1, 1'b0);
        wait_state(8'h04, 30);
        wait_state(8'h80, FT * TC + 20);
        outs(charger_pkg::CUR_ZERO, 3'h6);
        $display("test fast fault finished");
    endtask : t_fast_fault

    task automatic t_overtemp;
        do_reset(1'b1, 1'b0, 1'b1);
        wait_state(8'h80, 20);
        outs(charger_pkg::CUR_ZERO, 3'h6);
        $display("test overtemp finished");
    endtask : t_overtemp

    initial
    begin
        t_idle();
        t_cycle();
        t_prequal_fault();
        t_fast_fault();
        t_overtemp();
        test_done();
    end
endmodule : testbench
`default_nettype wire
